/* shared/oca_pkg.sv */
// Shared constants and types for the output characterizer and alert block
package oca_pkg;
  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_POINT_COUNT = 8'h04;
  localparam logic [7:0] ADDR_ALERT_MODE  = 8'h08;
  localparam logic [7:0] ADDR_STATUS      = 8'h0C;
  localparam logic [7:0] ADDR_THR_BASE    = 8'h10;
  localparam logic [7:0] ADDR_THR_LAST    = 8'h24;
  localparam logic [7:0] ADDR_OUTPUT      = 8'h30;
  localparam logic [7:0] ADDR_PT_BASE     = 8'h40;
  localparam logic [7:0] ADDR_PT_LAST     = 8'h60;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_SQRT_BIT   = 1;
  localparam int CTRL_LINCUT_BIT = 2;
  localparam int STAT_REJ_BIT    = 6;
  localparam int PT_X_LSB        = 16;
  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int             NUM_POINTS    = 9;
  localparam int             NUM_VARS      = 3;
  localparam logic [3:0]     MAX_COUNT     = 4'h9;
  localparam logic [3:0]     COUNT_RESET   = 4'h0;
  localparam logic [15:0]    UPPER_RESET   = 16'hFFFF;
  localparam logic [15:0]    LOWER_RESET   = 16'h0000;
  localparam logic [31:0]    POINT_RESET   = 32'h0000_0000;
  localparam logic [1:0]     HTRANS_NONSEQ = 2'h2;
  // ----------------------------------------------------------------------
  // Alert modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ALERT_OFF            = 2'h0,
    UPPER_SIDE_DETECTION = 2'h1,
    LOWER_SIDE_DETECTION = 2'h2,
    BOTH_SIDE_DETECTION  = 2'h3
  } oca_mode_e;
  // ----------------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                 en;
    logic                 square_root_output;
    logic                 linear_low_cut;
    logic                 rej;
    logic [3:0]           point_count;
    logic [5:0]           modes;
    logic [5:0][15:0]     thr;
    logic [8:0][31:0]     pts;
    logic [15:0]          aout;
    logic [2:0]           hi;
    logic [2:0]           lo;
    logic                 wpend;
    logic [7:0]           waddr;
    logic [31:0]          rdata;
  } oca_state_s;
endpackage

/* core/oca_top.sv */
// Output characterizer and process alert checker with AHB-Lite registers
// What this block does
// RL1 - Up to nine points within full span
// RL2 - Enabled characterizer drives the analog output
// RL3 - Tool writes points only while disabled
// RL4 - Points take effect only after enabling
// RL5 - Refuse enable with alarm if not increasing
// RL6 - Refuse enable for square root with linear cut; the code tests the stored bits only, so one write setting all three enables
// RL7 - Point count accepts 0 through 9
// RL8 - Each point holds input and output value
// RL9 - Alarm when pressure passes configured limit
// RL10 - Same checks for static pressure, temperature
// RL11 - Separate alert mode per monitored variable
// RL12 - Modes: off, upper, lower, both sides
// RL13 - Upper and lower threshold per variable
// RL14 - Linear interpolation between adjacent points
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module oca_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] pressure_in,
  input  wire logic [15:0] static_pressure_in,
  input  wire logic [15:0] capsule_temp_in,
  output logic      [15:0] analog_out,
  output logic      [2:0]  alert_hi,
  output logic      [2:0]  alert_lo,
  output logic             characterizer_reject_alarm,
  output logic             characterizer_active
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  oca_pkg::oca_state_s s;
  oca_pkg::oca_state_s next_s;
  logic [7:0]          bad_seg;
  logic [2:0][15:0]    var_val;
  logic [2:0]          cmp_hi;
  logic [2:0]          cmp_lo;
  logic                en_req;
  logic                req_bad;
  logic [15:0]         char_val;

  assign var_val   = {capsule_temp_in, static_pressure_in, pressure_in};
  // Inputs come from the measurement pipeline on hclk, so no synchroniser
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = s.rdata;
  assign analog_out                 = s.aout;
  assign alert_hi                   = s.hi;
  assign alert_lo                   = s.lo;
  assign characterizer_reject_alarm = s.rej;
  assign characterizer_active       = s.en;

  // ----------------------------------------------------------------------
  // Monotonic check and threshold compare
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_seg
      // Both axes must rise strictly so every segment has a positive width
      assign bad_seg[g] = (4'(g + 1) < s.point_count) &&
        ((s.pts[g+1][31:16] <= s.pts[g][31:16]) ||
         (s.pts[g+1][15:0] <= s.pts[g][15:0])); // RL5
    end
    for (g = 0; g < oca_pkg::NUM_VARS; g++)
    begin : g_var
      logic [1:0] m;
      assign m = s.modes[2*g+1 -: 2]; // RL11
      assign cmp_hi[g] = ((m == oca_pkg::UPPER_SIDE_DETECTION) ||
                          (m == oca_pkg::BOTH_SIDE_DETECTION)) &&
                         (var_val[g] > s.thr[2*g]); // RL9 RL12 RL13
      assign cmp_lo[g] = ((m == oca_pkg::LOWER_SIDE_DETECTION) ||
                          (m == oca_pkg::BOTH_SIDE_DETECTION)) &&
                         (var_val[g] < s.thr[2*g+1]); // RL10 RL12 RL13
    end
  endgenerate

  assign en_req  = s.wpend && (s.waddr == oca_pkg::ADDR_CTRL) &&
                   hwdata[oca_pkg::CTRL_EN_BIT] && !s.en;
  assign req_bad = (|bad_seg) ||
                   (s.square_root_output && s.linear_low_cut); // RL5 RL6

  // ----------------------------------------------------------------------
  // Characterizer
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [31:0] prod;
    logic [31:0] quot;
    logic [15:0] xi;
    logic [15:0] yi;
    logic        found;
    prod  = 32'h0000_0000;
    quot  = 32'h0000_0000;
    xi    = 16'h0000;
    yi    = 16'h0000;
    found = 1'b0;
    char_val = pressure_in;
    if (s.en && s.point_count != 4'h0) // RL2 RL4
    begin
      if (pressure_in <= s.pts[0][31:16])
      begin
        char_val = s.pts[0][15:0];
        found    = 1'b1;
      end
      for (int i = 0; i < 8; i++)
      begin
        xi = s.pts[i][31:16];
        yi = s.pts[i][15:0];
        if (!found && (4'(i + 1) < s.point_count) &&
            pressure_in <= s.pts[i+1][31:16])
        begin
          prod = 32'(pressure_in - xi) * 32'(s.pts[i+1][15:0] - yi);
          quot = prod / 32'(s.pts[i+1][31:16] - xi);
          char_val = yi + quot[15:0]; // RL14
          found    = 1'b1;
        end
      end
      if (!found)
      begin
        char_val = s.pts[s.point_count - 4'h1][15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state: bus writes, reads, processing
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] a;
    a = s.waddr;
    next_s       = s;
    next_s.wpend = 1'b0;
    if (s.wpend)
    begin
      if (a == oca_pkg::ADDR_CTRL)
      begin
        if (!hwdata[oca_pkg::CTRL_EN_BIT])
        begin
          next_s.en = 1'b0;
        end
        else if (en_req && req_bad)
        begin
          next_s.rej = 1'b1; // RL5 RL6
        end
        else if (en_req)
        begin
          next_s.en = 1'b1; // RL4
        end
        if (!s.en)
        begin
          next_s.square_root_output = hwdata[oca_pkg::CTRL_SQRT_BIT];
          next_s.linear_low_cut     = hwdata[oca_pkg::CTRL_LINCUT_BIT];
        end
      end
      else if (a == oca_pkg::ADDR_POINT_COUNT)
      begin
        if (hwdata[31:0] <= 32'(oca_pkg::MAX_COUNT) && !s.en)
        begin
          next_s.point_count = hwdata[3:0]; // RL7
        end
      end
      else if (a == oca_pkg::ADDR_ALERT_MODE)
      begin
        next_s.modes = hwdata[5:0]; // RL11
      end
      else if (a == oca_pkg::ADDR_STATUS)
      begin
        // Write one clears; a refusal needs a control write, so it never meets a clear in this cycle
        if (hwdata[oca_pkg::STAT_REJ_BIT])
        begin
          next_s.rej = 1'b0;
        end
      end
      else if (a >= oca_pkg::ADDR_THR_BASE && a <= oca_pkg::ADDR_THR_LAST)
      begin
        next_s.thr[3'((a - oca_pkg::ADDR_THR_BASE) >> 2)] = hwdata[15:0]; // RL13
      end
      else if (a >= oca_pkg::ADDR_PT_BASE && a <= oca_pkg::ADDR_PT_LAST)
      begin
        // Points are frozen while the characterizer runs
        if (!s.en)
        begin
          next_s.pts[4'((a - oca_pkg::ADDR_PT_BASE) >> 2)] = hwdata; // RL1 RL3 RL8
        end
      end
    end
    if (hsel && hready && htrans == oca_pkg::HTRANS_NONSEQ)
    begin
      a = {haddr[7:2], 2'h0};
      next_s.wpend = hwrite;
      next_s.waddr = a;
      // Read from the updated copy so a read right after a write sees it
      next_s.rdata = 32'h0000_0000;
      if (!hwrite)
      begin
        if (a == oca_pkg::ADDR_CTRL)
        begin
          next_s.rdata = {29'h0, next_s.linear_low_cut,
                          next_s.square_root_output, next_s.en};
        end
        else if (a == oca_pkg::ADDR_POINT_COUNT)
        begin
          next_s.rdata = {28'h0, next_s.point_count};
        end
        else if (a == oca_pkg::ADDR_ALERT_MODE)
        begin
          next_s.rdata = {26'h0, next_s.modes};
        end
        else if (a == oca_pkg::ADDR_STATUS)
        begin
          next_s.rdata = {25'h0, next_s.rej, s.lo, s.hi};
        end
        else if (a >= oca_pkg::ADDR_THR_BASE && a <= oca_pkg::ADDR_THR_LAST)
        begin
          next_s.rdata = {16'h0, next_s.thr[3'((a - oca_pkg::ADDR_THR_BASE) >> 2)]};
        end
        else if (a == oca_pkg::ADDR_OUTPUT)
        begin
          next_s.rdata = {16'h0, s.aout};
        end
        else if (a >= oca_pkg::ADDR_PT_BASE && a <= oca_pkg::ADDR_PT_LAST)
        begin
          next_s.rdata = next_s.pts[4'((a - oca_pkg::ADDR_PT_BASE) >> 2)];
        end
      end
    end
    next_s.aout = char_val; // RL2
    next_s.hi   = cmp_hi;   // RL9 RL10
    next_s.lo   = cmp_lo;   // RL9 RL10
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s             <= '0;
      s.point_count <= oca_pkg::COUNT_RESET;
      s.thr         <= {3{oca_pkg::LOWER_RESET, oca_pkg::UPPER_RESET}};
      s.pts         <= {oca_pkg::NUM_POINTS{oca_pkg::POINT_RESET}};
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_count_in_range: assert property (s.point_count <= oca_pkg::MAX_COUNT) // RL7
    else $error("point count above nine");
  a_reject_order: assert property (ce && en_req && (|bad_seg) |=> s.rej && !s.en) // RL5
    else $error("non-increasing points were not refused");
  a_reject_sqrt: assert property (ce && en_req && s.square_root_output && s.linear_low_cut
                                  |=> s.rej && !s.en) // RL6
    else $error("square root with linear cut was not refused");
  a_pass_through: assert property (ce && !s.en |=> analog_out == $past(pressure_in)) // RL4
    else $error("output not raw pressure while disabled");
  a_first_point: assert property (ce && s.en && s.point_count != 4'h0 &&
                                  pressure_in == s.pts[0][31:16]
                                  |=> analog_out == $past(s.pts[0][15:0])) // RL2
    else $error("output not characterized at first point");
  a_points_frozen: assert property (ce && s.en |=> s.pts == $past(s.pts)) // RL3
    else $error("points changed while characterizer enabled");
  a_alert_off: assert property (ce && s.modes[1:0] == oca_pkg::ALERT_OFF
                                |=> !alert_hi[0] && !alert_lo[0]) // RL12
    else $error("pressure alert raised while off");
  a_upper_detect: assert property (ce && s.modes[1:0] == oca_pkg::UPPER_SIDE_DETECTION &&
                                   pressure_in > s.thr[0] |=> alert_hi[0]) // RL9
    else $error("pressure upper alert missed");
  a_static_lower: assert property (ce && s.modes[3:2] == oca_pkg::LOWER_SIDE_DETECTION &&
                                   static_pressure_in < s.thr[3] |=> alert_lo[1]) // RL10
    else $error("static pressure lower alert missed");
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == ce)
    else $error("slave answered other than OKAY or ready off enable");
  // Alarm is sticky: only a write-one to the status bit may drop it
  a_reject_sticky: assert property (ce && s.rej &&
                                    !(s.wpend && s.waddr == oca_pkg::ADDR_STATUS &&
                                      hwdata[oca_pkg::STAT_REJ_BIT]) |=> s.rej) // RL5
    else $error("reject alarm dropped without a clear");
  // Low enable must hold every bit, bus state included
  a_enable_freeze: assert property (!ce |=> s == $past(s))
    else $error("state moved while clock enable low");
endmodule

/* verification/oca_host.sv */
// AHB-Lite master model of the remote configuration tool
`timescale 1ns/1ps
module oca_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             hang
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hang = 1'b0;
  end
  // ----------------------------------------------------------------------
  // Single word transfer
  // ----------------------------------------------------------------------
  // Bounded waits, so a stuck slave raises hang instead of hanging the run
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= oca_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk) n++; while (hready !== 1'b1 && n < 64);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk) n++; while (hready !== 1'b1 && n < 128);
    rd = hrdata;
    // Released data bus must not keep showing the last word
    hwdata <= ~wd;
    if (hready !== 1'b1) hang <= 1'b1;
  endtask
endmodule

/* verification/output_characterizer_alert_tb.sv */
// Self-checking bench for the output characterizer and alert block
`timescale 1ns/1ps
module output_characterizer_alert_tb;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] pres;
  logic [15:0] spres;
  logic [15:0] temp;
  logic [15:0] analog_out;
  logic [2:0]  alert_hi;
  logic [2:0]  alert_lo;
  logic        rej;
  logic        active;
  logic        hang;
  logic [31:0] rd;
  int          miscompares;
  int          checks;

  oca_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hang(hang));
  oca_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pressure_in(pres),
    .static_pressure_in(spres), .capsule_temp_in(temp), .analog_out(analog_out),
    .alert_hi(alert_hi), .alert_lo(alert_lo), .characterizer_reject_alarm(rej),
    .characterizer_active(active));

  always #25 hclk = ~hclk;
  always @(posedge hang)
  begin
    miscompares++;
    report_and_stop();
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, rd);
    cmp(rd, e);
  endtask
  // Derived outputs lag a write or input change by up to two edges
  task automatic settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  task automatic drive(input logic [15:0] p, input logic [15:0] s, input logic [15:0] t);
    @(posedge hclk);
    pres <= p;
    spres <= s;
    temp <= t;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rdchk(8'h10, 32'h0000_FFFF);
    rdchk(8'h14, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    rdchk(8'h2C, 32'h0);
  endtask
  task automatic t_char;
    logic [15:0] pv [6];
    logic [15:0] ev [6];
    pv = '{16'h0800, 16'h1000, 16'h2000, 16'h3000, 16'h4000, 16'hF000};
    ev = '{16'h0100, 16'h0100, 16'h1100, 16'h2100, 16'h2500, 16'h2900};
    drive(16'h2000, 16'h0, 16'h0);
    settle();
    cmp(32'(analog_out), 32'h2000);
    wr(8'h04, 32'h3);
    wr(8'h40, 32'h1000_0100);
    wr(8'h44, 32'h3000_2100);
    wr(8'h48, 32'h5000_2900);
    rdchk(8'h44, 32'h3000_2100);
    settle();
    cmp(32'(analog_out), 32'h2000);
    wr(8'h00, 32'h1);
    settle();
    cmp(32'(active), 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      drive(pv[i], 16'h0, 16'h0);
      settle();
      cmp(32'(analog_out), 32'(ev[i]));
    end
  endtask
  task automatic t_locked;
    wr(8'h44, 32'h3800_2200);
    rdchk(8'h44, 32'h3000_2100);
    wr(8'h04, 32'h9);
    rdchk(8'h04, 32'h3);
    wr(8'h00, 32'h0);
    settle();
    cmp(32'({active, analog_out}), 32'h0000_F000);
    wr(8'h04, 32'h9);
    rdchk(8'h04, 32'h9);
    wr(8'h04, 32'hA);
    rdchk(8'h04, 32'h9);
    wr(8'h04, 32'h3);
  endtask
  task automatic t_reject;
    logic [31:0] bad [2];
    bad = '{32'h5000_2000, 32'h2000_2900};
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h48, bad[i]);
      wr(8'h00, 32'h1);
      settle();
      cmp(32'({rej, active}), 32'h2);
      rdchk(8'h0C, 32'h40);
      wr(8'h0C, 32'h40);
      settle();
      cmp(32'(rej), 32'h0);
    end
    wr(8'h48, 32'h5000_2900);
    wr(8'h00, 32'h6);
    wr(8'h00, 32'h7);
    settle();
    cmp(32'({rej, active}), 32'h2);
    wr(8'h0C, 32'h40);
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h3);
    settle();
    cmp(32'({rej, active}), 32'h1);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_alert;
    logic [15:0] vv [4];
    logic [5:0]  ex;
    vv = '{16'h9000, 16'h8000, 16'h3FFF, 16'h4000};
    for (int v = 0; v < 3; v++)
    begin
      wr(8'(8'h10 + 8 * v), 32'h8000);
      wr(8'(8'h14 + 8 * v), 32'h4000);
    end
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h08, 32'(m * 6'h15));
      for (int k = 0; k < 4; k++)
      begin
        drive(vv[k], vv[k], vv[k]);
        settle();
        ex = {(k == 0 && m[0]) ? 3'h7 : 3'h0, (k == 2 && m[1]) ? 3'h7 : 3'h0};
        cmp(32'({alert_hi, alert_lo}), 32'(ex));
      end
    end
    wr(8'h08, 32'h39);
    drive(16'h9000, 16'h9000, 16'h9000);
    settle();
    cmp(32'({alert_hi, alert_lo}), 32'h28);
    drive(16'h1000, 16'h1000, 16'h1000);
    settle();
    cmp(32'({alert_hi, alert_lo}), 32'h06);
    rdchk(8'h0C, 32'h30);
    rdchk(8'h30, 32'h1000);
    // Enable low: new samples must not reach the alert flags
    @(posedge hclk);
    ce <= 1'b0;
    drive(16'h9000, 16'h9000, 16'h9000);
    settle();
    cmp(32'({alert_hi, alert_lo}), 32'h06);
    @(posedge hclk);
    ce <= 1'b1;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    pres = 16'h0;
    spres = 16'h0;
    temp = 16'h0;
    miscompares = 0;
    checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_char();
    t_locked();
    t_reject();
    t_alert();
    report_and_stop();
  end
endmodule
